//--- tta_pkg.sv
// constants, types and register map of the thermal threshold alert block
`default_nettype none
package tta_pkg;
  localparam int CLK_MHZ    = 250;
  localparam int CONV9_MS   = 30;
  localparam int CONV10_MS  = 60;
  localparam int CONV11_MS  = 120;
  localparam int CONV12_MS  = 240;
  localparam int POR_MS     = 2;
  localparam int CONV9_CYC  = CONV9_MS * 1000 * CLK_MHZ;
  localparam int CONV10_CYC = CONV10_MS * 1000 * CLK_MHZ;
  localparam int CONV11_CYC = CONV11_MS * 1000 * CLK_MHZ;
  localparam int CONV12_CYC = CONV12_MS * 1000 * CLK_MHZ;
  localparam int POR_CYC    = POR_MS * 1000 * CLK_MHZ;

  localparam logic [5:0] IDX_TEMP  = 6'h00;
  localparam logic [5:0] IDX_CFG   = 6'h01;
  localparam logic [5:0] IDX_LOWER = 6'h02;
  localparam logic [5:0] IDX_UPPER = 6'h03;

  localparam logic [15:0] RST_TEMP  = 16'h0000;
  localparam logic [15:0] RST_UPPER = 16'hA000;
  localparam logic [15:0] RST_LOWER = 16'h9600;
  localparam logic [7:0]  RST_CFG   = 8'h00;
  localparam logic [15:0] LIM_MASK  = 16'hFF80;
  localparam logic [7:0]  LIM_LO    = 8'h80;

  localparam int CFG_SD  = 0;
  localparam int CFG_INT = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_Q   = 3;
  localparam int CFG_RES = 5;
  localparam int CFG_OS  = 7;

  localparam logic [2:0] Q_N0 = 3'h1;
  localparam logic [2:0] Q_N1 = 3'h2;
  localparam logic [2:0] Q_N2 = 3'h4;
  localparam logic [2:0] Q_N3 = 3'h6;

  localparam logic [15:0] RES_M9  = 16'hFF80;
  localparam logic [15:0] RES_M10 = 16'hFFC0;
  localparam logic [15:0] RES_M11 = 16'hFFE0;
  localparam logic [15:0] RES_M12 = 16'hFFF0;

  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_CONV = 2'b01,
    ST_IDLE = 2'b11
  } tta_st_t;

  typedef struct packed {
    tta_st_t     st;
    logic [31:0] tmr;
    logic [15:0] temp;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [7:0]  cfg;
    logic        hot;
    logic        pend;
    logic [2:0]  qcnt;
    logic [15:0] s1;
    logic [15:0] s2;
    logic        ack;
    logic [31:0] dat;
    logic        alert;
  } tta_regs_t;
endpackage
`default_nettype wire

//--- tta_alert.sv
// thermal threshold alert and conversion control with wishbone registers
`timescale 1ns/1ps
`default_nettype none
module tta_alert
  import tta_pkg::*;
#(
  parameter int unsigned P_CONV9  = CONV9_CYC,
  parameter int unsigned P_CONV10 = CONV10_CYC,
  parameter int unsigned P_CONV11 = CONV11_CYC,
  parameter int unsigned P_CONV12 = CONV12_CYC,
  parameter int unsigned P_POR    = POR_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] temp_sample_i,
  output logic             alert_o
);

  tta_regs_t   s;
  tta_regs_t   n;
  logic        done;
  logic        rd;
  logic        wr;
  logic        ev;
  logic        sd_enter;
  logic        above;
  logic        below;
  logic        cond;
  logic        act;
  logic [2:0]  need;
  logic [15:0] res_m;
  logic [15:0] newt;
  logic [31:0] conv_cyc;
  logic [5:0]  idx;

  always_comb begin
    n = s;
    // sample bus crosses in through two flops; only s2 is read
    n.s1 = temp_sample_i;
    n.s2 = s.s1;
    ev = 1'b0;
    sd_enter = 1'b0;
    idx = wb_adr_i[7:2];
    rd = wb_cyc_i && wb_stb_i && !s.ack && !wb_we_i;
    wr = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i;
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    done = (s.st == ST_CONV) && (s.tmr == 32'h0000_0000);
    case (s.cfg[CFG_RES+:2])
      2'b00: begin
        conv_cyc = 32'(P_CONV9);
        res_m = RES_M9;
      end
      2'b01: begin
        conv_cyc = 32'(P_CONV10);
        res_m = RES_M10;
      end
      2'b10: begin
        conv_cyc = 32'(P_CONV11);
        res_m = RES_M11;
      end
      default: begin
        conv_cyc = 32'(P_CONV12);
        res_m = RES_M12;
      end
    endcase
    case (s.cfg[CFG_Q+:2])
      2'b00:   need = Q_N0;
      2'b01:   need = Q_N1;
      2'b10:   need = Q_N2;
      default: need = Q_N3;
    endcase
    newt = s.s2 & res_m;
    // limits keep nine upper bits, signed half-degree steps
    above = $signed(newt) > $signed(s.upper & LIM_MASK);
    below = $signed(newt) < $signed(s.lower & LIM_MASK);
    // comparator release is barred while in shutdown (one-shot runs)
    cond = s.hot ? (below && (s.cfg[CFG_INT] || !s.cfg[CFG_SD])) : above;
    if (s.tmr != 32'h0000_0000) begin
      n.tmr = s.tmr - 32'h0000_0001;
    end
    case (s.st)
      ST_POR: begin
        if (s.tmr == 32'h0000_0000) begin
          n.st = ST_CONV;
          n.tmr = conv_cyc;
          n.temp = RST_TEMP;
          n.upper = RST_UPPER;
          n.lower = RST_LOWER;
          n.cfg = RST_CFG;
          n.hot = 1'b0;
          n.pend = 1'b0;
          n.qcnt = 3'h0;
        end
      end
      ST_CONV: begin
        if (done) begin
          n.temp = newt;
          if (cond) begin
            if (s.qcnt + 3'h1 >= need) begin
              n.hot = !s.hot;
              n.qcnt = 3'h0;
              ev = 1'b1;
            end else begin
              n.qcnt = s.qcnt + 3'h1;
            end
          end else begin
            n.qcnt = 3'h0;
          end
          if (s.cfg[CFG_SD]) begin
            n.cfg[CFG_OS] = 1'b0;
            n.st = ST_IDLE;
            // shutdown landing on a finished conversion must still clear
            sd_enter = !s.cfg[CFG_OS];
          end else begin
            n.tmr = conv_cyc;
          end
        end else if (s.cfg[CFG_SD] && !s.cfg[CFG_OS]) begin
          // shutdown drops the conversion in flight, no result
          n.st = ST_IDLE;
          sd_enter = 1'b1;
        end
      end
      ST_IDLE: begin
        if (!s.cfg[CFG_SD] || s.cfg[CFG_OS]) begin
          n.st = ST_CONV;
          n.tmr = conv_cyc;
          n.qcnt = 3'h0;
        end
      end
      default: begin
        n.st = ST_POR;
      end
    endcase
    // pending interrupt: a new event beats a same-cycle read, shutdown beats both
    if (rd) begin
      n.pend = 1'b0;
    end
    if (ev) begin
      n.pend = 1'b1;
    end
    if (sd_enter) begin
      n.pend = 1'b0;
    end
    if (wr) begin
      case (idx)
        IDX_CFG: begin
          if (wb_sel_i[0]) begin
            n.cfg = wb_dat_i[7:0];
          end
        end
        IDX_LOWER: begin
          if (wb_sel_i[1]) begin
            n.lower[15:8] = wb_dat_i[15:8];
          end
          if (wb_sel_i[0]) begin
            n.lower[7:0] = wb_dat_i[7:0] & LIM_LO;
          end
        end
        IDX_UPPER: begin
          if (wb_sel_i[1]) begin
            n.upper[15:8] = wb_dat_i[15:8];
          end
          if (wb_sel_i[0]) begin
            n.upper[7:0] = wb_dat_i[7:0] & LIM_LO;
          end
        end
        default: begin
          n.dat = s.dat;
        end
      endcase
    end
    n.dat = 32'h0000_0000;
    if (rd) begin
      case (idx)
        IDX_TEMP:  n.dat = {16'h0000, s.temp};
        IDX_CFG:   n.dat = {24'h00_0000, s.cfg};
        IDX_LOWER: n.dat = {16'h0000, s.lower};
        IDX_UPPER: n.dat = {16'h0000, s.upper};
        default:   n.dat = 32'h0000_0000;
      endcase
    end
    act = n.cfg[CFG_INT] ? n.pend : n.hot;
    n.alert = n.cfg[CFG_POL] ? act : !act;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.st    <= ST_POR;
      s.tmr   <= 32'(P_POR);
      s.temp  <= RST_TEMP;
      s.upper <= RST_UPPER;
      s.lower <= RST_LOWER;
      s.cfg   <= RST_CFG;
      s.hot   <= 1'b0;
      s.pend  <= 1'b0;
      s.qcnt  <= 3'h0;
      s.s1    <= 16'h0000;
      s.s2    <= 16'h0000;
      s.ack   <= 1'b0;
      s.dat   <= 32'h0000_0000;
      s.alert <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign alert_o  = s.alert;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_alert_polarity: assert property (
    ##1 alert_o == (s.cfg[CFG_POL] ? (s.cfg[CFG_INT] ? s.pend : s.hot)
                                    : !(s.cfg[CFG_INT] ? s.pend : s.hot)))
    else $error("alert level disagrees with polarity and style");

  chk_comp_stable: assert property (
    (!done && s.st != ST_POR) |=> $stable(s.hot))
    else $error("comparator state moved without a conversion");

  chk_comp_sd_hold: assert property (
    (done && s.hot && !s.cfg[CFG_INT] && s.cfg[CFG_SD]) |=> s.hot)
    else $error("comparator released during one-shot");

  chk_int_read_clr: assert property (
    (rd && !ev && s.st != ST_POR) |=> !s.pend)
    else $error("register read did not clear the interrupt");

  chk_int_sd_clr: assert property (
    (sd_enter && s.st == ST_CONV) |=> (!s.pend && s.st == ST_IDLE))
    else $error("shutdown did not clear the interrupt");

  chk_queue_count: assert property (
    (done && !$past(s.st == ST_POR) && s.hot != n.hot) |-> (s.qcnt + 3'h1 == need))
    else $error("flag toggled at wrong queue count");

  chk_queue_restart: assert property (
    (done && !cond) |=> s.qcnt == 3'h0)
    else $error("queue count did not restart");

  chk_conv_time: assert property (
    (s.st == ST_IDLE && n.st == ST_CONV) |=> s.tmr == $past(conv_cyc))
    else $error("conversion time not loaded per resolution");

  chk_oneshot_end: assert property (
    (done && s.cfg[CFG_SD] && !wr) |=> (s.st == ST_IDLE && !s.cfg[CFG_OS]))
    else $error("one-shot did not end in shutdown");

  chk_por_wait: assert property (
    (s.st == ST_POR && s.tmr != 32'h0000_0000) |=> s.st == ST_POR)
    else $error("power-up delay cut short");

  chk_res_mask: assert property (
    done |=> (s.temp & ~$past(res_m)) == 16'h0000)
    else $error("temperature bits below resolution not zero");

  // guards on shutdown entry and wake, limit format, the event path, the conversion result and power-up defaults
  chk_sd_pend_clr: assert property (
    (s.st == ST_CONV && n.st == ST_IDLE && !s.cfg[CFG_OS]) |=> !s.pend)
    else $error("entering shutdown left the interrupt pending");

  chk_int_raise: assert property (
    (ev && !sd_enter && !wr && s.cfg[CFG_INT]) |=> (s.pend && alert_o == s.cfg[CFG_POL]))
    else $error("interrupt event did not drive the alert active");

  chk_comp_release: assert property (
    ($fell(s.hot) && !$past(s.cfg[CFG_INT])) |-> !$past(s.cfg[CFG_SD]))
    else $error("comparator released outside continuous conversion");

  chk_limit_low_zero: assert property (
    (s.upper[6:0] == 7'h00) && (s.lower[6:0] == 7'h00))
    else $error("limit bits below the half degree not zero");

  chk_temp_update: assert property (
    done |=> s.temp == $past(newt))
    else $error("temperature not updated at conversion end");

  chk_idle_temp_hold: assert property (
    (s.st == ST_IDLE) |=> $stable(s.temp))
    else $error("temperature changed while shut down");

  chk_queue_wake_restart: assert property (
    (s.st == ST_IDLE && n.st == ST_CONV) |=> s.qcnt == 3'h0)
    else $error("queue count kept across shutdown");

  chk_por_defaults: assert property (
    (s.st == ST_POR && s.tmr == 32'h0000_0000 && !wr)
      |=> (s.upper == RST_UPPER && s.lower == RST_LOWER && s.cfg == RST_CFG))
    else $error("defaults not loaded after power-up delay");

  cov_int_event: cover property (ev && s.cfg[CFG_INT]);
  cov_oneshot:   cover property (done && s.cfg[CFG_SD]);
  cov_read_clr:  cover property (rd && s.pend);
  cov_comp_rel:  cover property (ev && s.hot && !s.cfg[CFG_INT]);
  cov_sd_abort:  cover property (sd_enter && s.pend);

endmodule
`default_nettype wire

//--- tta_host.sv
// wishbone host model standing in for the controller on the far side
`timescale 1ns/1ps
`default_nettype none
module tta_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // one classic cycle; any read doubles as the interrupt acknowledge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    r = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // one idle cycle with cyc_o and stb_o low before the next request; the slave drops ack at the edge where it is seen
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- tb_tta_alert.sv
// self-checking bench for the thermal threshold alert block
`timescale 1ns/1ps
`default_nettype none
module tb_tta_alert;
  import tta_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] smp = 16'h1234;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        alert;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  // short counts keep the run small; one 9-bit conversion is about 21 cycles
  tta_alert #(.P_CONV9(20), .P_CONV10(30), .P_CONV11(40), .P_CONV12(50), .P_POR(10))
    u_tta_alert (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .temp_sample_i(smp), .alert_o(alert));

  tta_host u_tta_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  task automatic summarize();
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_tta_host.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    u_tta_host.xfer(1'b0, a, 32'h0000_0000, r);
    check(r, exp);
  endtask

  // let the edge's updates land before looking at the flag
  task automatic al(input logic exp);
    wt(2);
    check({31'h0, alert}, {31'h0, exp});
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    wt(2);
    rst <= 1'b0;
    @(posedge clk);
    al(1'b1);
    rd(8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_A000);
    rd(8'h08, 32'h0000_9600);
    rd(8'h04, 32'h0000_0000);
    wr(8'h10, 32'h0000_FFFF);
    rd(8'h10, 32'h0000_0000);
    wt(60);
    wr(8'h00, 32'h0000_FFFF);
    rd(8'h00, 32'h0000_1200);
    wr(8'h04, 32'h0000_0060);
    wt(120);
    rd(8'h00, 32'h0000_1230);
    wr(8'h0C, 32'h0000_20FF);
    rd(8'h0C, 32'h0000_2080);
    wr(8'h08, 32'h0000_1000);
    wr(8'h04, 32'h0000_0000);
    smp <= 16'h2100;
    wt(50);
    al(1'b0);
    smp <= 16'h1800;
    wt(50);
    al(1'b0);
    wr(8'h04, 32'h0000_0004);
    al(1'b1);
    wr(8'h04, 32'h0000_0000);
    smp <= 16'h0800;
    wt(50);
    al(1'b1);
    wr(8'h04, 32'h0000_0018);
    smp <= 16'h2100;
    wt(82);
    al(1'b1);
    wt(82);
    al(1'b0);
    smp <= 16'h0800;
    wt(82);
    al(1'b0);
    wt(82);
    al(1'b1);
    wr(8'h04, 32'h0000_0000);
    smp <= 16'h2100;
    wt(50);
    wr(8'h04, 32'h0000_0001);
    smp <= 16'h0800;
    wt(80);
    al(1'b0);
    wr(8'h04, 32'h0000_0081);
    wt(60);
    rd(8'h04, 32'h0000_0001);
    al(1'b0);
    wr(8'h04, 32'h0000_0000);
    wt(50);
    al(1'b1);
    wr(8'h04, 32'h0000_0002);
    rd(8'h10, 32'h0000_0000);
    al(1'b1);
    smp <= 16'h2100;
    wt(50);
    al(1'b0);
    rd(8'h10, 32'h0000_0000);
    al(1'b1);
    wt(50);
    al(1'b1);
    smp <= 16'h0800;
    wt(50);
    al(1'b0);
    wr(8'h04, 32'h0000_0003);
    al(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
